// *** core/swr_kick_edge.sv ***
// Edge detector for the watchdog kick input
`timescale 1ns/1ps
`default_nettype none
module swr_kick_edge (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Kick line
    input wire logic kick_in_i,
    output logic edge_o
);
    import swr_pkg::*;

    swr_kick_t s_q; // Registered state
    swr_kick_t s_d; // Next state

    ////////////////////////////////////////////////////////////////////////////
    // Next state: follow the line every cycle
    always_comb begin
        s_d = s_q;
        s_d.prev = kick_in_i;
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_q.prev <= KICK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Either direction of transition counts
    assign edge_o = (kick_in_i != s_q.prev);

endmodule : swr_kick_edge
`default_nettype wire

// *** core/swr_pkg.sv ***
// Shared constants, types and state layout for the supply watchdog reset generator
package swr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Time base
    localparam int unsigned CLK_MHZ = 20;          // Reference clock, MHz

    // Durations in microseconds, as printed
    localparam int unsigned T_PRI_US = 50000;      // Primary reset hold, 50 ms
    localparam int unsigned T_SEC_US = 10000;      // Extra secondary hold, 10 ms
    localparam int unsigned T_WD0_US = 750;        // Timeout, select 00: 0.75 ms
    localparam int unsigned T_WD1_US = 1500;       // Timeout, select 01: 1.5 ms
    localparam int unsigned T_WD2_US = 12500;      // Timeout, select 10: 12.5 ms
    localparam int unsigned T_WD3_US = 25000;      // Timeout, select 11: 25 ms

    // Cycle counts derived from the durations
    localparam int unsigned PRI_CYC = T_PRI_US * CLK_MHZ;
    localparam int unsigned SEC_CYC = T_SEC_US * CLK_MHZ;
    localparam int unsigned WD0_CYC = T_WD0_US * CLK_MHZ;
    localparam int unsigned WD1_CYC = T_WD1_US * CLK_MHZ;
    localparam int unsigned WD2_CYC = T_WD2_US * CLK_MHZ;
    localparam int unsigned WD3_CYC = T_WD3_US * CLK_MHZ;

    ////////////////////////////////////////////////////////////////////////////
    // Counter width, sized for the full 60 ms reset interval
    localparam int unsigned CNT_W = 21;
    typedef logic [CNT_W-1:0] swr_cnt_t;

    // Reset values
    localparam swr_cnt_t CNT_RST = 21'h000000;
    localparam logic RST_OUT_RST = 1'b0;           // Outputs held low in reset
    localparam logic KICK_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer states
    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,                           // Supply low, outputs low
        ST_PRI = 2'b01,                            // Timing primary hold
        ST_SEC = 2'b10,                            // Primary released, secondary timing
        ST_RUN = 2'b11                             // Both released, watchdog live
    } swr_st_t;

    // Timeout select pair
    typedef struct packed {
        logic hi;                                  // Second select
        logic lo;                                  // First select
    } swr_sel_t;

    // Main sequencer state
    typedef struct packed {
        swr_st_t st;                               // Sequencer state
        swr_cnt_t tmr;                             // Reset duration counter
        swr_cnt_t wdt;                             // Watchdog counter
        logic pri_n;                               // Primary reset, active low
        logic sec_n;                               // Secondary reset, active low
    } swr_state_t;

    // Kick edge detector state
    typedef struct packed {
        logic prev;                                // Last sampled kick level
    } swr_kick_t;

endpackage : swr_pkg

// *** core/swr_top.sv ***
// Supply watchdog reset generator: sequencer, watchdog and reset outputs
//
// Contract
// - Undervoltage drives both resets low immediately.
// - Primary stays low 50 ms after recovery.
// - Secondary releases 10 ms after primary.
// - Both resets assert in the same instant.
// - Missed kick within timeout forces both resets.
// - Watchdog reset: primary 50 ms, secondary 10 more.
// - Every kick edge restarts; processor kicks often.
// - Kicks ignored while primary reset is active.
// - Watchdog restarts when primary goes high.
// - Selects pick 0.75, 1.5, 12.5, 25 ms.
// - Undriven kick line suspends watchdog timeouts.
`timescale 1ns/1ps
`default_nettype none
module swr_top #(
    parameter swr_pkg::swr_cnt_t PRI_CYC_P = swr_pkg::swr_cnt_t'(swr_pkg::PRI_CYC),
    parameter swr_pkg::swr_cnt_t SEC_CYC_P = swr_pkg::swr_cnt_t'(swr_pkg::SEC_CYC),
    parameter swr_pkg::swr_cnt_t WD0_CYC_P = swr_pkg::swr_cnt_t'(swr_pkg::WD0_CYC),
    parameter swr_pkg::swr_cnt_t WD1_CYC_P = swr_pkg::swr_cnt_t'(swr_pkg::WD1_CYC),
    parameter swr_pkg::swr_cnt_t WD2_CYC_P = swr_pkg::swr_cnt_t'(swr_pkg::WD2_CYC),
    parameter swr_pkg::swr_cnt_t WD3_CYC_P = swr_pkg::swr_cnt_t'(swr_pkg::WD3_CYC)
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Supply monitor, high while supply is within tolerance
    input wire logic supply_sense_i,
    // Watchdog kick and its undriven/mid-supply indication
    input wire logic kick_in_i,
    input wire logic kick_in_float_i,
    // Timeout selects
    input wire logic tmo_sel_lo_i,
    input wire logic tmo_sel_hi_i,
    // Reset outputs, active low
    output logic rst_pri_n_o,
    output logic rst_sec_n_o
);
    import swr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    swr_state_t s_q; // Registered state
    swr_state_t s_d; // Next state
    swr_sel_t sel; // Select pair
    swr_cnt_t wd_last; // Last count of the chosen timeout
    logic kick_edge; // Transition seen on kick line
    logic wd_live; // Watchdog allowed to count

    // Timeout count for a select pair
    function automatic swr_cnt_t wd_limit(input swr_sel_t s);
        case ({s.hi, s.lo})
            2'b00: wd_limit = WD0_CYC_P;
            2'b01: wd_limit = WD1_CYC_P;
            2'b10: wd_limit = WD2_CYC_P;
            default: wd_limit = WD3_CYC_P;
        endcase
    endfunction : wd_limit

    assign sel = '{hi: tmo_sel_hi_i, lo: tmo_sel_lo_i};
    assign wd_last = wd_limit(sel) - swr_cnt_t'(1);
    assign wd_live = (s_q.st == ST_SEC) || (s_q.st == ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Kick edge detection
    swr_kick_edge u_kick (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .kick_in_i(kick_in_i),
        .edge_o(kick_edge)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer and watchdog next state
    always_comb begin
        s_d = s_q;
        case (s_q.st)
            // Waiting for the supply to return
            ST_HOLD: begin
                s_d.tmr = CNT_RST;
                s_d.wdt = CNT_RST;
                if (supply_sense_i) begin
                    s_d.st = ST_PRI;
                end
            end
            // Primary hold timing
            ST_PRI: begin
                s_d.wdt = CNT_RST;
                if (s_q.tmr == PRI_CYC_P - swr_cnt_t'(1)) begin
                    s_d.st = ST_SEC;
                    s_d.pri_n = 1'b1;
                    s_d.tmr = CNT_RST;
                    s_d.wdt = CNT_RST;
                end else begin
                    s_d.tmr = s_q.tmr + swr_cnt_t'(1);
                end
            end
            // Secondary extra hold
            ST_SEC: begin
                if (s_q.tmr == SEC_CYC_P - swr_cnt_t'(1)) begin
                    s_d.st = ST_RUN;
                    s_d.sec_n = 1'b1;
                    s_d.tmr = CNT_RST;
                end else begin
                    s_d.tmr = s_q.tmr + swr_cnt_t'(1);
                end
            end
            // Normal running
            ST_RUN: begin
                s_d.tmr = CNT_RST;
            end
            default: begin
                s_d.st = ST_HOLD;
            end
        endcase
        // Watchdog counts once the primary reset has released
        if (wd_live) begin
            if (kick_edge || kick_in_float_i) begin
                s_d.wdt = CNT_RST;
            end else if (s_q.wdt >= wd_last) begin
                s_d.st = ST_PRI;
                s_d.pri_n = 1'b0;
                s_d.sec_n = 1'b0;
                s_d.tmr = CNT_RST;
                s_d.wdt = CNT_RST;
            end else begin
                s_d.wdt = s_q.wdt + swr_cnt_t'(1);
            end
        end
        // Undervoltage overrides everything and restarts the sequence
        if (!supply_sense_i) begin
            s_d.st = ST_HOLD;
            s_d.pri_n = 1'b0;
            s_d.sec_n = 1'b0;
            s_d.tmr = CNT_RST;
            s_d.wdt = CNT_RST;
        end
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_q.st <= ST_HOLD;
            s_q.tmr <= CNT_RST;
            s_q.wdt <= CNT_RST;
            s_q.pri_n <= RST_OUT_RST;
            s_q.sec_n <= RST_OUT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs: gated by the supply so a dip pulls both low at once
    assign rst_pri_n_o = s_q.pri_n && supply_sense_i;
    assign rst_sec_n_o = s_q.sec_n && supply_sense_i;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_low_supply;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !supply_sense_i |-> (!rst_pri_n_o && !rst_sec_n_o);
    endproperty
    a_low_supply: assert property (p_low_supply)
        else $error("reset not asserted on undervoltage");

    property p_pri_release;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(s_q.pri_n) |-> ($past(s_q.st) == ST_PRI)
            && ($past(s_q.tmr) == PRI_CYC_P - swr_cnt_t'(1));
    endproperty
    a_pri_release: assert property (p_pri_release)
        else $error("primary released at wrong count");

    property p_sec_release;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(s_q.sec_n) |-> ($past(s_q.st) == ST_SEC)
            && ($past(s_q.tmr) == SEC_CYC_P - swr_cnt_t'(1)) && s_q.pri_n;
    endproperty
    a_sec_release: assert property (p_sec_release)
        else $error("secondary released at wrong count");

    property p_sec_with_pri;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !rst_pri_n_o |-> !rst_sec_n_o;
    endproperty
    a_sec_with_pri: assert property (p_sec_with_pri)
        else $error("secondary high while primary low");

    property p_wd_expire;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (s_q.st == ST_RUN) && (s_q.wdt >= wd_last) && !kick_edge && !kick_in_float_i
            && supply_sense_i |=> (s_q.st == ST_PRI) && !s_q.pri_n && !s_q.sec_n;
    endproperty
    a_wd_expire: assert property (p_wd_expire)
        else $error("watchdog expiry did not force reset");

    property p_kick_restart;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        wd_live && kick_edge |=> (s_q.wdt == CNT_RST);
    endproperty
    a_kick_restart: assert property (p_kick_restart)
        else $error("kick edge did not restart watchdog");

    property p_kick_ignored;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !s_q.pri_n |-> (s_q.wdt == CNT_RST);
    endproperty
    a_kick_ignored: assert property (p_kick_ignored)
        else $error("watchdog counting during primary reset");

    property p_wd_restart;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(s_q.pri_n) |-> (s_q.wdt == CNT_RST) ##1 (!s_q.pri_n || s_q.wdt <= swr_cnt_t'(1));
    endproperty
    a_wd_restart: assert property (p_wd_restart)
        else $error("watchdog not restarted at primary release");

    property p_float_hold;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (s_q.st == ST_RUN) && kick_in_float_i && supply_sense_i |=> s_q.pri_n;
    endproperty
    a_float_hold: assert property (p_float_hold)
        else $error("watchdog reset while kick line undriven");

    property p_dip_restart;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !supply_sense_i |=> (s_q.st == ST_HOLD) && (s_q.tmr == CNT_RST);
    endproperty
    a_dip_restart: assert property (p_dip_restart)
        else $error("undervoltage did not restart sequence");

endmodule : swr_top
`default_nettype wire

// *** dv/swr_cpu_model.sv ***
// Supervised processor model that toggles the watchdog kick line
`timescale 1ns/1ps
`default_nettype none
module swr_cpu_model (
    // Clock
    input wire logic clk_i,
    // Kick control: enable and toggle period in cycles
    input wire logic en_i,
    input wire logic [3:0] per_i,
    // Kick line towards the device
    output logic kick_o
);
    logic [3:0] cnt_q = 4'h0; // Cycles since last toggle
    logic kick_q = 1'b0; // Kick level, starts low
    assign kick_o = kick_q;
    ////////////////////////////////////////////////////////////////////////////
    // Toggle every per_i cycles while enabled, both edges serve as kicks
    always @(posedge clk_i) begin
        if (en_i && cnt_q >= per_i) begin
            kick_q <= ~kick_q;
            cnt_q <= 4'h1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule : swr_cpu_model
`default_nettype wire

// *** dv/swr_top_bench.sv ***
// Self-checking bench for the supply watchdog reset generator
`timescale 1ns/1ps
`default_nettype none
module swr_top_bench;
    import swr_pkg::*;
    typedef struct {int hi; int lo; int sec;} swr_note_t; // Zero in hi or lo means unchecked; sec is always checked
    localparam int PRI = 32'h14; // Shortened primary hold
    localparam int SEC = 32'h8; // Shortened secondary extra hold
    localparam int LIM [4] = '{32'ha, 32'hc, 32'he, 32'h10}; // Timeouts by select
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic supply_sense_i = 1'b1;
    logic kick_in_float_i = 1'b0;
    logic tmo_sel_lo_i = 1'b0;
    logic tmo_sel_hi_i = 1'b0;
    logic kick_en = 1'b1; // Processor kicks active
    logic [3:0] kick_per = 4'h3; // Kick period
    logic kick;
    logic rst_pri_n_o;
    logic rst_sec_n_o;
    logic [7:0] rnd = 8'h46; // Random state, seeded 70
    int error_cnt = 0;
    int tests_run = 0;
    swr_note_t notes [$]; // Expected reset pulses
    swr_note_t cur;
    int hi_cnt = 0, lo_cnt = 0, sec_cnt = 0, hi_seen = 0;
    bit prev_q = 1'b0, sec_on = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // Clock, partner and device
    initial forever #25 ref_clk_i = ~ref_clk_i;
    swr_cpu_model i_cpu (.clk_i(ref_clk_i), .en_i(kick_en), .per_i(kick_per), .kick_o(kick));
    // Durations follow the same shortened constants that the notes are built from
    swr_top #(
        .PRI_CYC_P(swr_cnt_t'(PRI)), .SEC_CYC_P(swr_cnt_t'(SEC)),
        .WD0_CYC_P(swr_cnt_t'(LIM[0])), .WD1_CYC_P(swr_cnt_t'(LIM[1])),
        .WD2_CYC_P(swr_cnt_t'(LIM[2])), .WD3_CYC_P(swr_cnt_t'(LIM[3]))
    ) i_dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .supply_sense_i(supply_sense_i),
        .kick_in_i(kick), .kick_in_float_i(kick_in_float_i), .tmo_sel_lo_i(tmo_sel_lo_i),
        .tmo_sel_hi_i(tmo_sel_hi_i), .rst_pri_n_o(rst_pri_n_o), .rst_sec_n_o(rst_sec_n_o)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #2;
    endtask : tick
    // Wait, bounded, until the primary reset shows level v
    task automatic wait_pri(input logic v);
        int n;
        n = 0;
        while (rst_pri_n_o !== v && n < 300) begin
            tick(1);
            n++;
        end
        chk(rst_pri_n_o, v);
    endtask : wait_pri
    // Supply low a, high b, low c, then back; note the whole low span
    task automatic blip(input int a, input int b, input int c);
        notes.push_back('{0, a + b + c + PRI + 1, SEC});
        supply_sense_i = 1'b0;
        #1;
        chk({rst_pri_n_o, rst_sec_n_o}, 2'b00);
        tick(a);
        supply_sense_i = 1'b1;
        tick(b);
        supply_sense_i = (c == 0);
        tick(c);
        supply_sense_i = 1'b1;
        wait_pri(1'b1);
        tick(SEC + 2);
    endtask : blip
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////
    // Watcher: measures each reset pulse and compares with the oldest note
    always @(negedge ref_clk_i) begin
        if (!sys_rst_i) begin
            if (rst_pri_n_o !== 1'b1) begin
                if (prev_q) begin // Falling primary
                    hi_seen = hi_cnt;
                    chk(rst_sec_n_o, 1'b0);
                    lo_cnt = 0;
                end
                lo_cnt++;
                sec_on = 1'b0;
            end else begin
                if (!prev_q) begin // Rising primary
                    if (notes.size() == 0) begin
                        chk(1'b1, 1'b0);
                    end else begin
                        cur = notes.pop_front();
                        if (cur.hi != 0) chk(hi_seen, cur.hi);
                        if (cur.lo != 0) chk(lo_cnt, cur.lo);
                    end
                    hi_cnt = 0;
                    sec_cnt = 0;
                    sec_on = 1'b1;
                end
                hi_cnt++;
                if (sec_on && rst_sec_n_o === 1'b1) begin
                    chk(sec_cnt, cur.sec);
                    sec_on = 1'b0;
                end else if (sec_on) begin
                    sec_cnt++;
                end
            end
            prev_q = (rst_pri_n_o === 1'b1);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        repeat (4000) @(posedge ref_clk_i);
        error_cnt++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        notes.push_back('{0, 0, SEC}); // Power-up pulse
        tick(10);
        sys_rst_i = 1'b0;
        // Watchdog expiry for every select code
        for (int s = 0; s < 4; s++) begin
            wait_pri(1'b0);
            {tmo_sel_hi_i, tmo_sel_lo_i} = s[1:0];
            kick_en = 1'b0;
            notes.push_back('{LIM[s], PRI, SEC});
            wait_pri(1'b1);
        end
        wait_pri(1'b0);
        kick_en = 1'b1;
        wait_pri(1'b1);
        tick(SEC + 2);
        $display("test watchdog done");
        // Toggling at random periods keeps the resets released
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            kick_per = 4'h1 + rnd[2:0];
            tick(20);
        end
        chk({rst_pri_n_o, rst_sec_n_o}, 2'b11);
        $display("test kick done");
        // Undriven kick line suspends expiry
        kick_en = 1'b0;
        kick_in_float_i = 1'b1;
        tick(3 * LIM[3]);
        chk({rst_pri_n_o, rst_sec_n_o}, 2'b11);
        kick_in_float_i = 1'b0;
        kick_en = 1'b1;
        $display("test float done");
        // Undervoltage pulses of random length, then a dip in mid-hold
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            blip(1 + rnd[2:0], 0, 0);
        end
        blip(3, 5, 2);
        $display("test supply done");
        close_out();
    end
endmodule : swr_top_bench
`default_nettype wire
